// ---- inc/mbm_pkg.sv ----
package mbm_pkg;
	// ***************************************************************
	// Register map (Modbus register numbers)
	// ***************************************************************
	localparam logic [15:0] ADDR_SLOT_FIRST = 16'h1389;
	localparam logic [15:0] ADDR_SLOT_LAST  = 16'h1398;
	localparam logic [15:0] VAL_SLOT_FIRST  = 16'h13bb;
	localparam logic [15:0] VAL_SLOT_SECOND = 16'h13bd;
	localparam logic [15:0] VAL_SLOT_LAST   = 16'h13d9;
	localparam logic [15:0] VAL_AREA_END    = 16'h13da;
	localparam logic [15:0] ADDR_SLOT_RESET = 16'h0000;
	localparam int          SLOT_COUNT      = 16;

	// ***************************************************************
	// Telegram limits (registers per telegram)
	// ***************************************************************
	localparam logic [6:0]  READ_MAX        = 7'h7d;
	localparam logic [6:0]  WRITE_MAX       = 7'h78;

	// ***************************************************************
	// Byte order settings
	// ***************************************************************
	localparam logic [1:0]  ORD_1032        = 2'h0;
	localparam logic [1:0]  ORD_0123        = 2'h1;
	localparam logic [1:0]  ORD_2301        = 2'h2;
	localparam logic [1:0]  ORD_3210        = 2'h3;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          PAR_TIMEOUT_NS  = 10000;
	localparam logic [7:0]  PAR_TIMEOUT_CYC = 8'(PAR_TIMEOUT_NS / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		T_IDLE   = 3'h0,
		T_LOAD   = 3'h1,
		T_PREP   = 3'h2,
		T_TX0    = 3'h3,
		T_TX1    = 3'h4,
		T_RX0    = 3'h5,
		T_RX1    = 3'h6,
		T_COMMIT = 3'h7
	} mbm_tg_t;

	typedef enum logic [1:0] {
		S_LOAD  = 2'h0,
		S_REQ   = 2'h1,
		S_STORE = 2'h2
	} mbm_scan_t;

	// Float byte index sent at sequence position pos
	function automatic logic [1:0] mbm_float_sel(input logic [1:0] ord, input logic [1:0] pos);
		case (ord)
			ORD_1032: return pos ^ 2'h1;
			ORD_0123: return pos;
			ORD_2301: return pos ^ 2'h2;
			default:  return pos ^ 2'h3;
		endcase
	endfunction : mbm_float_sel

	function automatic logic mbm_msb_first(input logic [1:0] ord);
		return (ord == ORD_1032) || (ord == ORD_3210);
	endfunction : mbm_msb_first
endpackage : mbm_pkg

// ---- hw/mbm_value_mem.sv ----
`timescale 1ns/100ps
// Value store for the data area, one 32-bit word per slot
module mbm_value_mem (
	input  wire logic        clk_in,
	input  wire logic        we_in,
	input  wire logic [3:0]  waddr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0]  raddr_in,
	output logic      [31:0] rdata_out
);
	logic [31:0] mem [0:15];

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule : mbm_value_mem

// ---- hw/mbm_data_map.sv ----
`timescale 1ns/100ps
module mbm_data_map (
	input  wire logic        REF_CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic [1:0]  BYTE_ORDER_IN,
	input  wire logic        TG_START_IN,
	input  wire logic        TG_WRITE_IN,
	input  wire logic [15:0] TG_ADDR_IN,
	input  wire logic [6:0]  TG_COUNT_IN,
	output logic             TG_BUSY_OUT,
	output logic             TG_DONE_OUT,
	output logic             TG_ERR_OUT,
	output logic             TX_VALID_OUT,
	output logic      [7:0]  TX_BYTE_OUT,
	input  wire logic        TX_READY_IN,
	input  wire logic        RX_VALID_IN,
	input  wire logic [7:0]  RX_BYTE_IN,
	output logic             RX_READY_OUT,
	output logic             PAR_REQ_OUT,
	output logic      [15:0] PAR_ADDR_OUT,
	input  wire logic        PAR_ACK_IN,
	input  wire logic [31:0] PAR_DATA_IN,
	input  wire logic        PAR_FLOAT_IN,
	input  wire logic        PAR_WRITABLE_IN,
	output logic             PAR_WR_OUT,
	output logic      [15:0] PAR_WADDR_OUT,
	output logic      [31:0] PAR_WDATA_OUT,
	input  wire logic [7:0]  STR_LEN_IN,
	input  wire logic [7:0]  STR_POS_IN,
	output logic      [7:0]  STR_IDX_OUT
);
	// ***************************************************************
	// Declarations
	// ***************************************************************
	mbm_pkg::mbm_tg_t   tg_state, next_tg_state;
	mbm_pkg::mbm_scan_t scan_state, next_scan_state;
	logic [15:0] cur_addr, next_cur_addr;
	logic [6:0]  cnt, next_cnt;
	logic        tg_write, next_tg_write;
	logic [7:0]  tx_byte, next_tx_byte;
	logic [7:0]  tx_spare, next_tx_spare;
	logic [7:0]  rx_b0, next_rx_b0;
	logic [7:0]  rx_b1, next_rx_b1;
	logic [31:0] wacc, next_wacc;
	logic        have_lo, next_have_lo;
	logic        done, next_done;
	logic        err, next_err;
	logic        par_wr, next_par_wr;
	logic [15:0] par_waddr, next_par_waddr;
	logic [31:0] par_wdata, next_par_wdata;
	logic [15:0] aslot [0:15];
	logic [15:0] slot_float, slot_wr;
	logic [3:0]  scan_slot, next_scan_slot;
	logic [15:0] par_addr, next_par_addr;
	logic [7:0]  scan_tmo, next_scan_tmo;
	logic [31:0] scan_val, next_scan_val;
	logic        scan_flt, next_scan_flt;
	logic        scan_wrb, next_scan_wrb;
	logic [7:0]  str_idx, next_str_idx;
	logic [15:0] doff, last_addr, aword, int_val;
	logic [3:0]  aidx, dslot;
	logic        dhalf, is_aslot, msb_first, tg_we, aslot_we;
	logic        mem_we;
	logic [3:0]  mem_waddr;
	logic [31:0] mem_wdata, mem_rdata;
	logic [1:0]  sel0, sel1;

	assign msb_first = mbm_pkg::mbm_msb_first(BYTE_ORDER_IN);
	assign is_aslot  = cur_addr <= mbm_pkg::ADDR_SLOT_LAST;
	assign aidx      = 4'(cur_addr - mbm_pkg::ADDR_SLOT_FIRST);
	assign doff      = cur_addr - mbm_pkg::VAL_SLOT_FIRST;
	assign dslot     = doff[4:1];
	assign dhalf     = doff[0];
	assign aword     = aslot[aidx];
	assign sel0      = mbm_pkg::mbm_float_sel(BYTE_ORDER_IN, {dhalf, 1'b0});
	assign sel1      = mbm_pkg::mbm_float_sel(BYTE_ORDER_IN, {dhalf, 1'b1});
	assign int_val   = msb_first ? {rx_b0, rx_b1} : {rx_b1, rx_b0};
	assign last_addr = TG_ADDR_IN + {9'h000, TG_COUNT_IN} - 16'h0001;

	// ***************************************************************
	// Address slots
	// ***************************************************************
	assign aslot_we = (tg_state == mbm_pkg::T_COMMIT) && is_aslot;
	generate
		for (genvar n = 0; n < mbm_pkg::SLOT_COUNT; n++) begin : g_aslot
			logic [15:0] next_word;
			always_comb begin
				next_word = aslot[n];
				if (aslot_we && (aidx == 4'(n))) begin
					next_word = int_val;
				end
			end
			always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
				if (!NRST_IN) begin
					aslot[n] <= mbm_pkg::ADDR_SLOT_RESET;
				end else begin
					aslot[n] <= next_word;
				end
			end
		end
	endgenerate

	// ***************************************************************
	// Telegram engine
	// ***************************************************************
	// Serves one window per telegram; a request that strays outside the
	// two slot windows is refused whole so no partial block is returned.
	always_comb begin
		next_tg_state  = tg_state;
		next_cur_addr  = cur_addr;
		next_cnt       = cnt;
		next_tg_write  = tg_write;
		next_tx_byte   = tx_byte;
		next_tx_spare  = tx_spare;
		next_rx_b0     = rx_b0;
		next_rx_b1     = rx_b1;
		next_wacc      = wacc;
		next_have_lo   = have_lo;
		next_done      = 1'b0;
		next_err       = 1'b0;
		next_par_wr    = 1'b0;
		next_par_waddr = par_waddr;
		next_par_wdata = par_wdata;
		tg_we          = 1'b0;
		mem_wdata      = scan_val;
		case (tg_state)
			mbm_pkg::T_IDLE: begin
				if (TG_START_IN) begin
					if ((TG_COUNT_IN == 7'h00) || (last_addr < TG_ADDR_IN) ||
					    (TG_COUNT_IN > (TG_WRITE_IN ? mbm_pkg::WRITE_MAX
					                                : mbm_pkg::READ_MAX)) ||
					    !(((TG_ADDR_IN >= mbm_pkg::ADDR_SLOT_FIRST) &&
					       (last_addr <= mbm_pkg::ADDR_SLOT_LAST)) ||
					      ((TG_ADDR_IN >= mbm_pkg::VAL_SLOT_FIRST) &&
					       (last_addr <= mbm_pkg::VAL_AREA_END)))) begin
						next_err = 1'b1;
					end else begin
						next_cur_addr = TG_ADDR_IN;
						next_cnt      = TG_COUNT_IN;
						next_tg_write = TG_WRITE_IN;
						next_have_lo  = 1'b0;
						next_tg_state = TG_WRITE_IN ? mbm_pkg::T_RX0 : mbm_pkg::T_LOAD;
					end
				end
			end
			mbm_pkg::T_LOAD: begin
				next_tg_state = mbm_pkg::T_PREP;
			end
			mbm_pkg::T_PREP: begin
				if (is_aslot) begin
					next_tx_byte  = msb_first ? aword[15:8] : aword[7:0];
					next_tx_spare = msb_first ? aword[7:0]  : aword[15:8];
				end else if (slot_float[dslot]) begin
					next_tx_byte  = mem_rdata[{sel0, 3'h0} +: 8];
					next_tx_spare = mem_rdata[{sel1, 3'h0} +: 8];
				end else if (!dhalf) begin
					next_tx_byte  = msb_first ? mem_rdata[15:8] : mem_rdata[7:0];
					next_tx_spare = msb_first ? mem_rdata[7:0]  : mem_rdata[15:8];
				end else begin
					// Second register of an integer slot carries nothing
					next_tx_byte  = 8'h00;
					next_tx_spare = 8'h00;
				end
				next_tg_state = mbm_pkg::T_TX0;
			end
			mbm_pkg::T_TX0: begin
				if (TX_READY_IN) begin
					next_tx_byte  = tx_spare;
					next_tg_state = mbm_pkg::T_TX1;
				end
			end
			mbm_pkg::T_RX0: begin
				if (RX_VALID_IN) begin
					next_rx_b0    = RX_BYTE_IN;
					next_tg_state = mbm_pkg::T_RX1;
				end
			end
			mbm_pkg::T_RX1: begin
				if (RX_VALID_IN) begin
					next_rx_b1    = RX_BYTE_IN;
					next_tg_state = mbm_pkg::T_COMMIT;
				end
			end
			default: begin
				// T_TX1 and T_COMMIT both close one register
				if ((tg_state == mbm_pkg::T_COMMIT) || TX_READY_IN) begin
					if ((tg_state == mbm_pkg::T_COMMIT) && !is_aslot) begin
						next_have_lo = 1'b0;
						if (slot_float[dslot]) begin
							next_wacc[{sel0, 3'h0} +: 8] = rx_b0;
							next_wacc[{sel1, 3'h0} +: 8] = rx_b1;
							next_have_lo = !dhalf;
							tg_we = dhalf && have_lo && slot_wr[dslot];
							mem_wdata = next_wacc;
						end else begin
							tg_we = !dhalf && slot_wr[dslot];
							mem_wdata = {16'h0000, int_val};
						end
						if (tg_we) begin
							next_par_wr    = 1'b1;
							next_par_waddr = aslot[dslot];
							next_par_wdata = mem_wdata;
						end
					end
					next_cur_addr = cur_addr + 16'h0001;
					next_cnt      = cnt - 7'h01;
					if (cnt == 7'h01) begin
						next_done     = 1'b1;
						next_tg_state = mbm_pkg::T_IDLE;
					end else begin
						next_tg_state = tg_write ? mbm_pkg::T_RX0 : mbm_pkg::T_LOAD;
					end
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tg_state  <= mbm_pkg::T_IDLE;
			cur_addr  <= 16'h0000;
			cnt       <= 7'h00;
			tg_write  <= 1'b0;
			tx_byte   <= 8'h00;
			tx_spare  <= 8'h00;
			rx_b0     <= 8'h00;
			rx_b1     <= 8'h00;
			wacc      <= 32'h0000_0000;
			have_lo   <= 1'b0;
			done      <= 1'b0;
			err       <= 1'b0;
			par_wr    <= 1'b0;
			par_waddr <= 16'h0000;
			par_wdata <= 32'h0000_0000;
		end else begin
			tg_state  <= next_tg_state;
			cur_addr  <= next_cur_addr;
			cnt       <= next_cnt;
			tg_write  <= next_tg_write;
			tx_byte   <= next_tx_byte;
			tx_spare  <= next_tx_spare;
			rx_b0     <= next_rx_b0;
			rx_b1     <= next_rx_b1;
			wacc      <= next_wacc;
			have_lo   <= next_have_lo;
			done      <= next_done;
			err       <= next_err;
			par_wr    <= next_par_wr;
			par_waddr <= next_par_waddr;
			par_wdata <= next_par_wdata;
		end
	end

	// ***************************************************************
	// Cyclic refresh of the value slots
	// ***************************************************************
	// A telegram write owns the memory port; a pending store just waits a
	// cycle, and a silent parameter is skipped after a timeout so one bad
	// entry cannot stall the whole list.
	assign mem_we    = tg_we || (scan_state == mbm_pkg::S_STORE);
	assign mem_waddr = tg_we ? dslot : scan_slot;

	always_comb begin
		next_scan_state = scan_state;
		next_scan_slot  = scan_slot;
		next_par_addr   = par_addr;
		next_scan_tmo   = scan_tmo;
		next_scan_val   = scan_val;
		next_scan_flt   = scan_flt;
		next_scan_wrb   = scan_wrb;
		case (scan_state)
			mbm_pkg::S_LOAD: begin
				next_par_addr   = aslot[scan_slot];
				next_scan_tmo   = 8'h00;
				next_scan_state = mbm_pkg::S_REQ;
			end
			mbm_pkg::S_REQ: begin
				next_scan_tmo = scan_tmo + 8'h01;
				if (PAR_ACK_IN) begin
					next_scan_val   = PAR_DATA_IN;
					next_scan_flt   = PAR_FLOAT_IN;
					next_scan_wrb   = PAR_WRITABLE_IN;
					next_scan_state = mbm_pkg::S_STORE;
				end else if (scan_tmo == mbm_pkg::PAR_TIMEOUT_CYC) begin
					next_scan_slot  = scan_slot + 4'h1;
					next_scan_state = mbm_pkg::S_LOAD;
				end
			end
			default: begin
				if (!tg_we) begin
					next_scan_slot  = scan_slot + 4'h1;
					next_scan_state = mbm_pkg::S_LOAD;
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			scan_state <= mbm_pkg::S_LOAD;
			scan_slot  <= 4'h0;
			par_addr   <= 16'h0000;
			scan_tmo   <= 8'h00;
			scan_val   <= 32'h0000_0000;
			scan_flt   <= 1'b0;
			scan_wrb   <= 1'b0;
			slot_float <= 16'h0000;
			slot_wr    <= 16'h0000;
		end else begin
			scan_state <= next_scan_state;
			scan_slot  <= next_scan_slot;
			par_addr   <= next_par_addr;
			scan_tmo   <= next_scan_tmo;
			scan_val   <= next_scan_val;
			scan_flt   <= next_scan_flt;
			scan_wrb   <= next_scan_wrb;
			if ((scan_state == mbm_pkg::S_STORE) && !tg_we) begin
				slot_float[scan_slot] <= scan_flt;
				slot_wr[scan_slot]    <= scan_wrb;
			end
		end
	end

	mbm_value_mem u_mem (
		.clk_in    (REF_CLK_IN),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (dslot),
		.rdata_out (mem_rdata)
	);

	// ***************************************************************
	// String byte sequencer
	// ***************************************************************
	always_comb begin
		next_str_idx = STR_LEN_IN - 8'h01 - STR_POS_IN;
		if (!msb_first) begin
			next_str_idx = next_str_idx ^ 8'h01;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			str_idx <= 8'h00;
		end else begin
			str_idx <= next_str_idx;
		end
	end

	assign TG_BUSY_OUT   = tg_state != mbm_pkg::T_IDLE;
	assign TG_DONE_OUT   = done;
	assign TG_ERR_OUT    = err;
	assign TX_VALID_OUT  = (tg_state == mbm_pkg::T_TX0) || (tg_state == mbm_pkg::T_TX1);
	assign TX_BYTE_OUT   = tx_byte;
	assign RX_READY_OUT  = (tg_state == mbm_pkg::T_RX0) || (tg_state == mbm_pkg::T_RX1);
	assign PAR_REQ_OUT   = scan_state == mbm_pkg::S_REQ;
	assign PAR_ADDR_OUT  = par_addr;
	assign PAR_WR_OUT    = par_wr;
	assign PAR_WADDR_OUT = par_waddr;
	assign PAR_WDATA_OUT = par_wdata;
	assign STR_IDX_OUT   = str_idx;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	localparam int TMO_BOUND = 252;
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!NRST_IN);

	read_limit_a: assert property (
		tg_state == mbm_pkg::T_IDLE && TG_START_IN && !TG_WRITE_IN
		&& TG_COUNT_IN > mbm_pkg::READ_MAX |=> TG_ERR_OUT && !TG_BUSY_OUT)
		else $error("read over 125 registers not refused");
	write_limit_a: assert property (
		tg_state == mbm_pkg::T_IDLE && TG_START_IN && TG_WRITE_IN
		&& TG_COUNT_IN > mbm_pkg::WRITE_MAX |=> TG_ERR_OUT && !TG_BUSY_OUT)
		else $error("write over 120 registers not refused");
	int_order_a: assert property (
		tg_state == mbm_pkg::T_PREP && is_aslot && msb_first
		|=> TX_BYTE_OUT == $past(aword[15:8]))
		else $error("integer high byte not sent first");
	float_order_a: assert property (
		tg_state == mbm_pkg::T_PREP && !is_aslot
		&& slot_float[dslot] && !dhalf && BYTE_ORDER_IN == mbm_pkg::ORD_1032
		|=> TX_BYTE_OUT == $past(mem_rdata[15:8]))
		else $error("default float order does not start with byte 1");
	ro_slot_a: assert property (
		tg_state == mbm_pkg::T_COMMIT && !is_aslot && !slot_wr[dslot]
		|=> !PAR_WR_OUT)
		else $error("write reached a read-only value slot");
	par_wr_a: assert property (
		tg_we |=> PAR_WR_OUT && PAR_WDATA_OUT == $past(mem_wdata))
		else $error("slot write not passed to parameter");
	store_adv_a: assert property (
		scan_state == mbm_pkg::S_REQ && PAR_ACK_IN
		|=> scan_state == mbm_pkg::S_STORE ##[1:3] scan_state == mbm_pkg::S_LOAD)
		else $error("fetched value not stored");
	req_bound_a: assert property (
		$rose(PAR_REQ_OUT) |-> ##[1:TMO_BOUND] !PAR_REQ_OUT)
		else $error("parameter fetch not bounded");
	tx_hold_a: assert property (
		TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
		else $error("transmit byte changed while stalled");

	read_done_c: cover property (tg_state == mbm_pkg::T_TX1 && TX_READY_IN && cnt == 7'h01);
	write_slot_c: cover property (tg_we && slot_float[dslot]);
	scan_skip_c: cover property (scan_state == mbm_pkg::S_REQ
		&& scan_tmo == mbm_pkg::PAR_TIMEOUT_CYC && !PAR_ACK_IN);
	refused_c: cover property (TG_ERR_OUT);
endmodule : mbm_data_map

// ---- sim/mbm_par_model.sv ----
`timescale 1ns/100ps
// Parameter store stand-in: answers each fetch promptly or after a delay
module mbm_par_model (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        slow_in,
	input  wire logic        req_in,
	input  wire logic [15:0] addr_in,
	output logic             ack_out,
	output logic      [31:0] data_out,
	output logic             float_out,
	output logic             writable_out
);
	logic [3:0] wait_cnt;

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_out <= 1'b0;
			wait_cnt <= 4'h0;
			data_out <= 32'h0;
			float_out <= 1'b0;
			writable_out <= 1'b0;
		end else if (ack_out || !req_in || wait_cnt != 4'h0) begin
			ack_out <= 1'b0;
			if (req_in && !ack_out)
				wait_cnt <= wait_cnt - 4'h1;
			// Released lines never keep the last answer
			data_out <= ~data_out;
			float_out <= ~float_out;
			writable_out <= ~writable_out;
		end else begin
			ack_out <= 1'b1;
			data_out <= {addr_in ^ 16'h5a5a, addr_in};
			float_out <= addr_in[0];
			writable_out <= addr_in[1];
			wait_cnt <= slow_in ? {addr_in[2:0], 1'b1} : 4'h0;
		end
	end
endmodule : mbm_par_model

// ---- sim/mbm_data_map_tb.sv ----
`timescale 1ns/100ps
module mbm_data_map_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [1:0]  ord = 2'h0;
	logic        start = 1'b0;
	logic        wr = 1'b0;
	logic [15:0] addr = 16'h0;
	logic [6:0]  cnt = 7'h0;
	logic        tx_rdy = 1'b0;
	logic        rx_vld = 1'b0;
	logic [7:0]  rx_b = 8'h0;
	logic [7:0]  s_len = 8'h0;
	logic [7:0]  s_pos = 8'h0;
	logic        slow = 1'b0;
	logic        busy, done, err, tx_vld, rx_rdy, p_req, p_ack, p_flt, p_wbl, p_wr;
	logic [7:0]  tx_b, s_idx;
	logic [15:0] p_addr, p_waddr;
	logic [31:0] p_data, p_wdata, w32;
	logic [48:0] w_note;
	logic [15:0] slot_a [16];
	logic [7:0]  tx_q [$];
	logic [7:0]  rx_q [$];
	logic [48:0] wr_q [$];
	logic [1:0]  fxs [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
	int          mismatches = 0;
	int          comparisons = 0;
	int          seed = 39;

	always #20 clk = ~clk;

	mbm_data_map i_dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .BYTE_ORDER_IN(ord),
		.TG_START_IN(start), .TG_WRITE_IN(wr), .TG_ADDR_IN(addr), .TG_COUNT_IN(cnt),
		.TG_BUSY_OUT(busy), .TG_DONE_OUT(done), .TG_ERR_OUT(err), .TX_VALID_OUT(tx_vld),
		.TX_BYTE_OUT(tx_b), .TX_READY_IN(tx_rdy), .RX_VALID_IN(rx_vld), .RX_BYTE_IN(rx_b),
		.RX_READY_OUT(rx_rdy), .PAR_REQ_OUT(p_req), .PAR_ADDR_OUT(p_addr),
		.PAR_ACK_IN(p_ack), .PAR_DATA_IN(p_data), .PAR_FLOAT_IN(p_flt),
		.PAR_WRITABLE_IN(p_wbl), .PAR_WR_OUT(p_wr), .PAR_WADDR_OUT(p_waddr),
		.PAR_WDATA_OUT(p_wdata), .STR_LEN_IN(s_len), .STR_POS_IN(s_pos), .STR_IDX_OUT(s_idx));

	mbm_par_model i_par (.clk_in(clk), .nrst_in(nrst), .slow_in(slow), .req_in(p_req),
		.addr_in(p_addr), .ack_out(p_ack), .data_out(p_data), .float_out(p_flt),
		.writable_out(p_wbl));

	// ***************************************************************
	// Checking helpers
	// ***************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (e !== s) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	function automatic logic [15:0] io(input logic [15:0] x);
		return (ord == 2'h0 || ord == 2'h3) ? x : {x[7:0], x[15:8]};
	endfunction : io

	function automatic logic [15:0] fr(input logic [31:0] v, input logic h);
		logic [1:0] fx;
		fx = fxs[ord] ^ {h, 1'b0};
		return {v[8*fx+:8], v[8*(fx^2'h1)+:8]};
	endfunction : fr

	function automatic logic [15:0] exp_reg(input logic [15:0] r);
		logic [15:0] a;
		if (r < 16'h13bb)
			return io(slot_a[4'(r - 16'h1389)]);
		a = slot_a[4'((r - 16'h13bb) >> 1)];
		if (a[0])
			return fr({a ^ 16'h5a5a, a}, ~r[0]);
		// Integer slot leaves its end register empty
		return r[0] ? io(a) : 16'h0000;
	endfunction : exp_reg

	task automatic put16(input logic [15:0] x);
		rx_q.push_back(x[15:8]);
		rx_q.push_back(x[7:0]);
	endtask : put16

	task automatic tg(input logic w, input logic [15:0] a, input logic [6:0] n, input logic e);
		int k;
		start <= 1'b1;
		wr <= w;
		addr <= a;
		cnt <= n;
		@(posedge clk);
		start <= 1'b0;
		while (!e && rx_q.size() > 0) begin
			rx_vld <= 1'b1;
			rx_b <= rx_q.pop_front();
			do @(negedge clk); while (rx_rdy !== 1'b1);
			@(posedge clk);
		end
		rx_vld <= 1'b0;
		k = 0;
		do begin
			@(negedge clk);
			k++;
			if (done !== 1'b1 && err !== 1'b1)
				chk("busy", 1, busy);
		end while (done !== 1'b1 && err !== 1'b1 && k < 3000);
		chk("outcome", e ? 3'b010 : 3'b100, {done, err, busy});
		@(posedge clk);
	endtask : tg

	task automatic rd(input logic [15:0] a, input logic [6:0] n);
		logic [15:0] x;
		for (int i = 0; i < n; i++) begin
			x = exp_reg(a + 16'(i));
			tx_q.push_back(x[15:8]);
			tx_q.push_back(x[7:0]);
		end
		tg(1'b0, a, n, 1'b0);
		chk("tx_left", 0, tx_q.size());
	endtask : rd

	always @(posedge clk)
		tx_rdy <= 1'($random(seed));

	always @(negedge clk) begin
		if (tx_vld === 1'b1 && tx_rdy === 1'b1)
			chk("tx_byte", tx_q.size() ? 32'(tx_q.pop_front()) : 32'hdead, 32'(tx_b));
		if (p_wr === 1'b1 && wr_q.size() == 0)
			chk("par_wr", 0, 1);
		else if (p_wr === 1'b1) begin
			w_note = wr_q.pop_front();
			chk("wr_addr", 32'(w_note[47:32]), 32'(p_waddr));
			chk("wr_data", w_note[31:0], w_note[48] ? p_wdata : 32'(p_wdata[15:0]));
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		conclude();
	end

	// ***************************************************************
	// Test sequence
	// ***************************************************************
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		ord <= 2'($random(seed));
		@(posedge clk);
		foreach (slot_a[i])
			slot_a[i] = 16'($random(seed));
		slot_a[0] = 16'h0102;
		slot_a[1] = 16'h0101;
		slot_a[2] = 16'h0103;
		foreach (slot_a[i])
			put16(io(slot_a[i]));
		tg(1'b1, 16'h1389, 7'h10, 1'b0);
		slow <= 1'b1;
		repeat (600) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			ord <= 2'(k);
			@(posedge clk);
			rd(16'h1389, 7'h10);
			rd(16'h13bb, 7'h20);
		end
		tg(1'b0, 16'h13bb, 7'h00, 1'b1);
		tg(1'b0, 16'h13bb, 7'h7e, 1'b1);
		tg(1'b1, 16'h13bb, 7'h79, 1'b1);
		tg(1'b0, 16'h1398, 7'h02, 1'b1);
		tg(1'b0, 16'h13db, 7'h01, 1'b1);
		tg(1'b1, 16'h13d9, 7'h03, 1'b1);
		ord <= 2'($random(seed));
		@(posedge clk);
		w32 = $random(seed);
		put16(io(w32[15:0]));
		wr_q.push_back({1'b0, 16'h0102, 16'h0000, w32[15:0]});
		tg(1'b1, 16'h13bb, 7'h01, 1'b0);
		put16(fr(w32, 1'b0));
		put16(fr(w32, 1'b1));
		tg(1'b1, 16'h13bd, 7'h02, 1'b0);
		put16(fr(w32, 1'b0));
		put16(fr(w32, 1'b1));
		wr_q.push_back({1'b1, 16'h0103, w32});
		tg(1'b1, 16'h13bf, 7'h02, 1'b0);
		for (int k = 0; k < 4; k++) begin
			for (int p = 0; p < 18; p++) begin
				s_len <= 8'h12;
				ord <= 2'(k);
				s_pos <= 8'(p);
				@(posedge clk);
				@(negedge clk);
				chk("str_idx", 8'(17 - p) ^ 8'(k == 1 || k == 2), s_idx);
				@(posedge clk);
			end
		end
		repeat (5) @(posedge clk);
		chk("wr_left", 0, wr_q.size());
		conclude();
	end
endmodule : mbm_data_map_tb
